//--- src/crpm_top.sv
// Shared pin multiplexer for platform resets, card reader and GPIO port 1
//
// Overview of operation
// - Reset pins A, B, D buffer bus reset
// - Reset C optionally ANDs external reset input
// - Card clock: high, low default, programmable rates
// - Presence low means inserted; raises power-on event
// - Active-low card power switch output
// - Serial data pin drives and receives
// - Card reset output on its pin
// - Third function maps pins to GPIO bits 4..0
// - Software registers choose each pin's function
// - Power pin carries main power-good output
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module crpm_top
  import crpm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic lpcResetN,
  input wire logic externalResetInN,
  input wire logic mainPowerGood,
  input wire logic [4:0] pinIn,
  output logic [4:0] pinOut,
  output logic [4:0] pinDriveN,
  output logic powerOnEvent,
  output logic cardSerialIn
);

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] sel, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res & mask;
  endfunction

  logic [31:0] funcSel_r, funcSel_nxt;
  logic [31:0] clkCfg_r, clkCfg_nxt;
  logic [31:0] cardCtrl_r, cardCtrl_nxt;
  logic [31:0] gpioOut_r, gpioOut_nxt;
  logic [31:0] gpioOe_r, gpioOe_nxt;
  logic [31:0] rstCfg_r, rstCfg_nxt;
  logic [31:0] rdData_r, rdData_nxt;
  logic ack_r, ack_nxt;
  logic [7:0] clkCnt_r, clkCnt_nxt;
  logic cardClk_r, cardClk_nxt;
  logic presentPrev_r, presentPrev_nxt;
  logic eventSticky_r, eventSticky_nxt;
  logic powerOnEvent_r, powerOnEvent_nxt;
  logic serialIn_r, serialIn_nxt;
  logic [4:0] pinOut_r, pinOut_nxt;
  logic [4:0] pinDriveN_r, pinDriveN_nxt;
  logic wrStrobe, reqNew, cardPresent, insertEvent;
  logic platformResetOutAN, platformResetOutBN, platformResetOutCN, platformResetOutDN;
  logic cardResetOut, cardPowerSwitchN, cardSerialOut;
  logic [4:0] firstLvl, secondLvl, thirdLvl, level;
  logic [7:0] halfCnt;
  logic [4:0] gpioInPort;

  // Function chosen for one pin
  function automatic crpm_func_t funcOf(input logic [31:0] sel, input int pin);
    return crpm_func_t'(sel[2*pin +: 2]);
  endfunction

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Bus handshake: answer one cycle after request, write at ack edge
  assign reqNew = wb_cyc_i && wb_stb_i && !ack_r;
  assign wrStrobe = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;

  // Next register values from bus writes
  always_comb begin
    funcSel_nxt = funcSel_r;
    clkCfg_nxt = clkCfg_r;
    cardCtrl_nxt = cardCtrl_r;
    gpioOut_nxt = gpioOut_r;
    gpioOe_nxt = gpioOe_r;
    rstCfg_nxt = rstCfg_r;
    if (wrStrobe) begin
      if (wb_adr_i == OFS_FUNC_SEL) begin
        funcSel_nxt = mergeBytes(funcSel_r, wb_dat_i, wb_sel_i, MASK_FUNC_SEL);
      end else if (wb_adr_i == OFS_CLK_CFG) begin
        clkCfg_nxt = mergeBytes(clkCfg_r, wb_dat_i, wb_sel_i, MASK_CLK_CFG);
      end else if (wb_adr_i == OFS_CARD_CTRL) begin
        cardCtrl_nxt = mergeBytes(cardCtrl_r, wb_dat_i, wb_sel_i, MASK_CARD_CTRL);
      end else if (wb_adr_i == OFS_GPIO_OUT) begin
        gpioOut_nxt = mergeBytes(gpioOut_r, wb_dat_i, wb_sel_i, MASK_GPIO);
      end else if (wb_adr_i == OFS_GPIO_OE) begin
        gpioOe_nxt = mergeBytes(gpioOe_r, wb_dat_i, wb_sel_i, MASK_GPIO);
      end else if (wb_adr_i == OFS_RST_CFG) begin
        rstCfg_nxt = mergeBytes(rstCfg_r, wb_dat_i, wb_sel_i, MASK_RST_CFG);
      end
    end
  end

  // Read data and acknowledge, unmapped reads return zero
  always_comb begin
    ack_nxt = reqNew;
    rdData_nxt = rdData_r;
    if (reqNew) begin
      rdData_nxt = 32'h0000_0000;
      if (wb_adr_i == OFS_FUNC_SEL) begin
        rdData_nxt = funcSel_r;
      end else if (wb_adr_i == OFS_CLK_CFG) begin
        rdData_nxt = clkCfg_r;
      end else if (wb_adr_i == OFS_CARD_CTRL) begin
        rdData_nxt = cardCtrl_r;
      end else if (wb_adr_i == OFS_GPIO_OUT) begin
        rdData_nxt = gpioOut_r;
      end else if (wb_adr_i == OFS_GPIO_OE) begin
        rdData_nxt = gpioOe_r;
      end else if (wb_adr_i == OFS_STATUS) begin
        rdData_nxt[STAT_PRESENT] = presentPrev_r;
        rdData_nxt[STAT_EVENT] = eventSticky_r;
        rdData_nxt[STAT_SERIAL_IN] = serialIn_r;
        rdData_nxt[STAT_GPIO_LSB +: 5] = gpioInPort;
      end else if (wb_adr_i == OFS_RST_CFG) begin
        rdData_nxt = rstCfg_r;
      end
    end
  end

  // Register file and bus state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      funcSel_r <= RST_FUNC_SEL;
      clkCfg_r <= RST_CLK_CFG;
      cardCtrl_r <= RST_CARD_CTRL;
      gpioOut_r <= RST_GPIO_OUT;
      gpioOe_r <= RST_GPIO_OE;
      rstCfg_r <= RST_RST_CFG;
      rdData_r <= 32'h0000_0000;
      ack_r <= 1'b0;
    end else begin
      funcSel_r <= funcSel_nxt;
      clkCfg_r <= clkCfg_nxt;
      cardCtrl_r <= cardCtrl_nxt;
      gpioOut_r <= gpioOut_nxt;
      gpioOe_r <= gpioOe_nxt;
      rstCfg_r <= rstCfg_nxt;
      rdData_r <= rdData_nxt;
      ack_r <= ack_nxt;
    end
  end

  a_select_write: assert property (
    (wrStrobe && wb_adr_i == OFS_FUNC_SEL && wb_sel_i[0])
      |=> (funcSel_r[7:0] == $past(wb_dat_i[7:0])))
    else $error("function select write not stored");

  // Card clock divider, half period chosen by source
  always_comb begin
    case (crpm_clksrc_t'(clkCfg_r[1:0]))
      CS_HIGH: halfCnt = HI_HALF;
      CS_PROG: halfCnt = (clkCfg_r[CLK_PROG_LSB +: 8] == 8'h00) ? 8'h01
                         : clkCfg_r[CLK_PROG_LSB +: 8];
      default: halfCnt = LO_HALF;
    endcase
    clkCnt_nxt = 8'h00;
    cardClk_nxt = 1'b0;
    if (cardCtrl_r[CTRL_CLK_EN]) begin
      if (clkCnt_r >= halfCnt - 8'h01) begin
        cardClk_nxt = !cardClk_r;
      end else begin
        clkCnt_nxt = clkCnt_r + 8'h01;
        cardClk_nxt = cardClk_r;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clkCnt_r <= 8'h00;
      cardClk_r <= 1'b0;
    end else begin
      clkCnt_r <= clkCnt_nxt;
      cardClk_r <= cardClk_nxt;
    end
  end

  a_clock_high: assert property (
    (cardCtrl_r[CTRL_CLK_EN] && clkCfg_r[1:0] == CS_HIGH && clkCnt_r == HI_HALF - 8'h01)
      |=> (cardClk_r != $past(cardClk_r)) && (clkCnt_r == 8'h00))
    else $error("high speed card clock half period wrong");
  a_clock_low: assert property (
    (cardCtrl_r[CTRL_CLK_EN] && clkCfg_r[1:0] == CS_LOW && clkCnt_r < LO_HALF - 8'h01)
      |=> (cardClk_r == $past(cardClk_r)))
    else $error("low speed card clock toggled early");

  // Per-function pin levels
  assign platformResetOutAN = lpcResetN;
  assign platformResetOutBN = lpcResetN;
  assign platformResetOutDN = lpcResetN;
  assign platformResetOutCN = rstCfg_r[RST_CFG_AND_BIT] ? (lpcResetN & externalResetInN)
                              : lpcResetN;
  assign cardResetOut = cardCtrl_r[CTRL_CARD_RESET];
  assign cardPowerSwitchN = !cardCtrl_r[CTRL_POWER_EN];
  assign cardSerialOut = cardCtrl_r[CTRL_SERIAL_OUT];
  assign firstLvl = {platformResetOutDN, platformResetOutCN, platformResetOutBN,
                     mainPowerGood, platformResetOutAN};
  assign secondLvl = {1'b1, cardClk_r, cardSerialOut, cardPowerSwitchN, cardResetOut};

  // Pin mux, one lane per pin with its GPIO bit in reverse order
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    assign thirdLvl[i] = gpioOe_r[PIN_COUNT-1-i] ? gpioOut_r[PIN_COUNT-1-i] : 1'b1;
    assign gpioInPort[PIN_COUNT-1-i] = pinIn[i];
    always_comb begin
      case (funcOf(funcSel_r, i))
        FN_FIRST: level[i] = firstLvl[i];
        FN_SECOND: level[i] = secondLvl[i];
        FN_THIRD: level[i] = thirdLvl[i];
        default: level[i] = 1'b1;
      endcase
    end
  end

  // Open-drain: drive only a low level, release a high one
  assign cardPresent = (funcOf(funcSel_r, 4) == FN_SECOND) && !pinIn[4];
  assign insertEvent = cardPresent && !presentPrev_r;

  always_comb begin
    pinOut_nxt = level;
    pinDriveN_nxt = level;
    presentPrev_nxt = cardPresent;
    powerOnEvent_nxt = insertEvent;
    serialIn_nxt = pinIn[2];
    eventSticky_nxt = eventSticky_r;
    if (wrStrobe && wb_adr_i == OFS_STATUS && wb_sel_i[0] && wb_dat_i[STAT_EVENT]) begin
      eventSticky_nxt = 1'b0;
    end
    if (insertEvent) begin
      eventSticky_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinOut_r <= 5'h1f;
      pinDriveN_r <= 5'h1f;
      presentPrev_r <= 1'b0;
      powerOnEvent_r <= 1'b0;
      serialIn_r <= 1'b1;
      eventSticky_r <= 1'b0;
    end else begin
      pinOut_r <= pinOut_nxt;
      pinDriveN_r <= pinDriveN_nxt;
      presentPrev_r <= presentPrev_nxt;
      powerOnEvent_r <= powerOnEvent_nxt;
      serialIn_r <= serialIn_nxt;
      eventSticky_r <= eventSticky_nxt;
    end
  end

  a_reset_a_copy: assert property (
    (funcOf(funcSel_r, 0) == FN_FIRST) |=> (pinOut_r[0] == $past(lpcResetN)))
    else $error("reset A does not follow bus reset");
  a_reset_bd_copy: assert property (
    (funcOf(funcSel_r, 2) == FN_FIRST && funcOf(funcSel_r, 4) == FN_FIRST)
      |=> (pinOut_r[2] == $past(lpcResetN)) && (pinDriveN_r[4] == $past(lpcResetN)))
    else $error("reset B or D does not follow bus reset");
  a_reset_c_gate: assert property (
    (funcOf(funcSel_r, 3) == FN_FIRST)
      |=> (pinOut_r[3] == ($past(lpcResetN)
           && ($past(externalResetInN) || !$past(rstCfg_r[RST_CFG_AND_BIT])))))
    else $error("reset C gating wrong");
  a_present_event: assert property (
    (funcOf(funcSel_r, 4) == FN_SECOND && !pinIn[4] && !presentPrev_r)
      |=> powerOnEvent_r && eventSticky_r ##1 !powerOnEvent_r)
    else $error("card insertion did not raise one event pulse");
  a_power_switch: assert property (
    (funcOf(funcSel_r, 1) == FN_SECOND)
      |=> (pinDriveN_r[1] == !$past(cardCtrl_r[CTRL_POWER_EN])))
    else $error("card power switch level wrong");
  a_serial_release: assert property (
    (funcOf(funcSel_r, 2) == FN_SECOND && cardCtrl_r[CTRL_SERIAL_OUT]) |=> pinDriveN_r[2])
    else $error("serial data pin not released for receive");
  a_card_reset: assert property (
    (funcOf(funcSel_r, 0) == FN_SECOND)
      |=> (pinOut_r[0] == $past(cardCtrl_r[CTRL_CARD_RESET])))
    else $error("card reset level wrong");
  a_gpio_map: assert property (
    (funcOf(funcSel_r, 0) == FN_THIRD && gpioOe_r[4] && !gpioOut_r[4]) |=> !pinDriveN_r[0])
    else $error("GPIO bit 4 not on first pin");
  a_power_good: assert property (
    (funcOf(funcSel_r, 1) == FN_FIRST) |=> (pinOut_r[1] == $past(mainPowerGood)))
    else $error("power good level wrong");
  a_func_exclusive: assert property (
    (funcOf(funcSel_r, 3) == FN_THIRD && !gpioOe_r[1]) |=> pinDriveN_r[3])
    else $error("unselected function drives pin");

  // Outputs straight from flip-flops
  assign wb_dat_o = rdData_r;
  assign wb_ack_o = ack_r;
  assign pinOut = pinOut_r;
  assign pinDriveN = pinDriveN_r;
  assign powerOnEvent = powerOnEvent_r;
  assign cardSerialIn = serialIn_r;

endmodule // crpm_top
`default_nettype wire

//--- pkg/crpm_pkg.sv
// Constants and types for the card reader and reset pin multiplexer
package crpm_pkg;
  // Clock and card clock rates
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CARD_CLK_HI_HZ = 7_100_000;
  localparam int unsigned CARD_CLK_LO_HZ = 3_500_000;
  localparam logic [7:0] HI_HALF = 8'(CLK_HZ / (2 * CARD_CLK_HI_HZ));
  localparam logic [7:0] LO_HALF = 8'(CLK_HZ / (2 * CARD_CLK_LO_HZ));
  localparam int PIN_COUNT = 5;
  // Register byte offsets
  localparam logic [7:0] OFS_FUNC_SEL = 8'h00;
  localparam logic [7:0] OFS_CLK_CFG = 8'h04;
  localparam logic [7:0] OFS_CARD_CTRL = 8'h08;
  localparam logic [7:0] OFS_GPIO_OUT = 8'h0c;
  localparam logic [7:0] OFS_GPIO_OE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_RST_CFG = 8'h2c;
  // Writable bit masks
  localparam logic [31:0] MASK_FUNC_SEL = 32'h0000_03ff;
  localparam logic [31:0] MASK_CLK_CFG = 32'h0000_ff03;
  localparam logic [31:0] MASK_CARD_CTRL = 32'h0000_000f;
  localparam logic [31:0] MASK_GPIO = 32'h0000_001f;
  localparam logic [31:0] MASK_RST_CFG = 32'h0000_0002;
  // Reset values
  localparam logic [31:0] RST_FUNC_SEL = 32'h0000_0000;
  localparam logic [31:0] RST_CLK_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_CARD_CTRL = 32'h0000_0004;
  localparam logic [31:0] RST_GPIO_OUT = 32'h0000_001f;
  localparam logic [31:0] RST_GPIO_OE = 32'h0000_0000;
  localparam logic [31:0] RST_RST_CFG = 32'h0000_0000;
  // Field positions
  localparam int RST_CFG_AND_BIT = 1;
  localparam int CTRL_CARD_RESET = 0;
  localparam int CTRL_POWER_EN = 1;
  localparam int CTRL_SERIAL_OUT = 2;
  localparam int CTRL_CLK_EN = 3;
  localparam int CLK_PROG_LSB = 8;
  localparam int STAT_PRESENT = 0;
  localparam int STAT_EVENT = 1;
  localparam int STAT_SERIAL_IN = 2;
  localparam int STAT_GPIO_LSB = 8;
  // Pin function per two-bit field
  typedef enum logic [1:0] {
    FN_FIRST = 2'b00,
    FN_SECOND = 2'b01,
    FN_THIRD = 2'b11,
    FN_NONE = 2'b10
  } crpm_func_t;
  // Card clock source
  typedef enum logic [1:0] {
    CS_LOW = 2'b00,
    CS_HIGH = 2'b01,
    CS_PROG = 2'b11,
    CS_SPARE = 2'b10
  } crpm_clksrc_t;
endpackage

//--- sim/crpm_card_socket.sv
// Card socket and reset loads on the open-drain shared pins
`timescale 1ns/100ps
`default_nettype none
module crpm_card_socket (
  input wire logic [4:0] pinDriveN,
  input wire logic cardInserted,
  input wire logic cardTx,
  output logic [4:0] pinIn
);
  // Pull-ups win unless the device or the card pulls low
  always_comb begin
    pinIn = pinDriveN;
    pinIn[2] = pinDriveN[2] & cardTx;
    pinIn[4] = pinDriveN[4] & ~cardInserted;
  end
endmodule // crpm_card_socket
`default_nettype wire

//--- sim/crpm_top_bench.sv
// Self-checking bench for the shared pin multiplexer
`timescale 1ns/100ps
`default_nettype none
module crpm_top_bench;
  import crpm_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, powerOnEvent, cardSerialIn;
  logic lpc = 1'b0, ext = 1'b1, pg = 1'b0, cardIn = 1'b0, cardTx = 1'b1;
  logic [4:0] pinIn, pinOut, pinDriveN;
  int errors = 0, checks = 0, cycles = 0, h, n;
  localparam logic [7:0] RA[7] = '{OFS_FUNC_SEL, OFS_CLK_CFG, OFS_CARD_CTRL, OFS_GPIO_OUT,
    OFS_GPIO_OE, OFS_RST_CFG, 8'h30};
  localparam logic [31:0] RV[7] = '{RST_FUNC_SEL, RST_CLK_CFG, RST_CARD_CTRL, RST_GPIO_OUT,
    RST_GPIO_OE, RST_RST_CFG, 32'h0};
  localparam logic [31:0] RM[7] = '{MASK_FUNC_SEL, MASK_CLK_CFG, MASK_CARD_CTRL, MASK_GPIO,
    MASK_GPIO, MASK_RST_CFG, 32'h0};

  // Clock and hang guard
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      close_out();
    end
  end

  crpm_top dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .lpcResetN(lpc), .externalResetInN(ext), .mainPowerGood(pg),
    .pinIn(pinIn), .pinOut(pinOut), .pinDriveN(pinDriveN), .powerOnEvent(powerOnEvent),
    .cardSerialIn(cardSerialIn));
  crpm_card_socket sock_u (.pinDriveN(pinDriveN), .cardInserted(cardIn), .cardTx(cardTx),
    .pinIn(pinIn));

  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check_val(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic cycle, held until ack is sampled high
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    // Ack ends this wait; only the bench hang guard bounds it
    do begin
      @(posedge sys_clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  // Expected pad levels from the selected functions
  function automatic logic [4:0] expPins(logic [9:0] fs, logic [3:0] ctl, logic [9:0] g,
      logic and2, logic [2:0] lv);
    logic [4:0] e;
    for (int i = 0; i < 5; i++) begin
      case (fs[2*i +: 2])
        2'b00: e[i] = (i == 1) ? lv[2] : (i == 3 && and2) ? lv[0] & lv[1] : lv[0];
        2'b01: e[i] = (i == 0) ? ctl[0] : (i == 1) ? ~ctl[1] : (i == 2) ? ctl[2] : (i == 4);
        2'b11: e[i] = g[9-i] ? g[4-i] : 1'b1;
        default: e[i] = 1'b1;
      endcase
    end
    return e;
  endfunction

  task automatic mux_case(logic [9:0] fs, logic [3:0] ctl, logic [9:0] g, logic and2,
      logic [2:0] lv);
    logic [31:0] r;
    wr(OFS_FUNC_SEL, {22'h0, fs});
    wr(OFS_CARD_CTRL, {28'h0, ctl});
    wr(OFS_GPIO_OUT, {27'h0, g[4:0]});
    wr(OFS_GPIO_OE, {27'h0, g[9:5]});
    wr(OFS_RST_CFG, {30'h0, and2, 1'b0});
    lpc <= lv[0];
    ext <= lv[1];
    pg <= lv[2];
    repeat (4) @(posedge sys_clk);
    check_val("pinOut", {27'h0, expPins(fs, ctl, g, and2, lv)}, {27'h0, pinOut});
    check_val("pinDriveN", {27'h0, expPins(fs, ctl, g, and2, lv)}, {27'h0, pinDriveN});
    wb(1'b0, OFS_STATUS, 32'h0, r);
    check_val("gpioIn", {27'h0, pinIn[0], pinIn[1], pinIn[2], pinIn[3], pinIn[4]},
      {27'h0, r[12:8]});
  endtask

  // Measures the run between the first and second card clock edges
  task automatic clk_case(logic [15:0] cfg, int half);
    logic v;
    int run, seen;
    wr(OFS_CLK_CFG, {16'h0, cfg});
    repeat (40) @(posedge sys_clk);
    v = pinOut[3];
    run = 0;
    seen = 0;
    repeat (3 * half + 4) begin
      @(posedge sys_clk);
      run++;
      if (pinOut[3] !== v) begin
        seen++;
        if (seen == 2) check_val("halfPeriod", 32'(half), 32'(run));
        v = pinOut[3];
        run = 0;
      end
    end
    check_val("clockRuns", 32'h1, 32'(seen >= 2));
  endtask

  // Main sequence
  initial begin
    void'($urandom(53685));
    repeat (8) @(posedge sys_clk);
    check_val("resetPins", 32'h1f, {27'h0, pinOut});
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    lpc <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, RA[i], 32'h0, q);
      check_val("resetValue", RV[i], q);
      wr(RA[i], 32'hffff_ffff);
      wb(1'b0, RA[i], 32'h0, q);
      check_val("writeMask", RM[i], q);
    end
    $display("test registers done");
    mux_case(10'h000, 4'h4, 10'h000, 1'b0, 3'b110);
    mux_case(10'h000, 4'h4, 10'h3ff, 1'b0, 3'b011);
    mux_case(10'h000, 4'h4, 10'h000, 1'b1, 3'b101);
    mux_case(10'h000, 4'h4, 10'h000, 1'b0, 3'b101);
    mux_case(10'h155, 4'h3, 10'h3ff, 1'b1, 3'b000);
    mux_case(10'h155, 4'h4, 10'h000, 1'b0, 3'b111);
    mux_case(10'h3ff, 4'h0, 10'h3ea, 1'b1, 3'b000);
    mux_case(10'h2aa, 4'h0, 10'h3e0, 1'b0, 3'b000);
    for (int k = 0; k < 40; k++) begin
      q = $urandom();
      mux_case(q[9:0], {1'b0, q[12:10]}, q[22:13], q[23], q[26:24]);
    end
    $display("test pin functions done");
    lpc <= 1'b1;
    wr(OFS_FUNC_SEL, 32'h040);
    wr(OFS_CARD_CTRL, 32'hc);
    clk_case(16'h0000, int'(LO_HALF));
    clk_case(16'h0001, int'(HI_HALF));
    clk_case(16'h0002, int'(LO_HALF));
    clk_case(16'h0003, 1);
    h = $urandom_range(2, 20);
    clk_case({h[7:0], 8'h03}, h);
    $display("test card clock done");
    wr(OFS_FUNC_SEL, 32'h154);
    wr(OFS_CARD_CTRL, 32'h4);
    wr(OFS_STATUS, 32'h2);
    cardIn <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (powerOnEvent !== 1'b1 && n < 10);
    check_val("eventPulse", 32'h1, {31'h0, powerOnEvent});
    @(posedge sys_clk);
    check_val("eventDrop", 32'h0, {31'h0, powerOnEvent});
    wb(1'b0, OFS_STATUS, 32'h0, q);
    check_val("eventSticky", 32'h3, {30'h0, q[1:0]});
    wr(OFS_STATUS, 32'h2);
    wb(1'b0, OFS_STATUS, 32'h0, q);
    check_val("eventClear", 32'h1, {30'h0, q[1:0]});
    cardTx <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check_val("serialLow", 32'h0, {31'h0, cardSerialIn});
    cardTx <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check_val("serialHigh", 32'h1, {31'h0, cardSerialIn});
    $display("test card socket done");
    close_out();
  end
endmodule // crpm_top_bench
`default_nettype wire
